/* File: hdl/toa_pkg.sv */
// constants, types and helpers of the offset, config and alert-mask bank
// assumes one 200 MHz clock and an AHB-Lite master on the register port
//
// Summary of operation
// - remote 1 results get the signed remote 1 offset, half degree per unit.
// - local results get the signed local offset added, half degree per unit.
// - remote 2 results get the signed remote 2 offset, half degree per unit.
// - with the lock bit set, offset and config writes are dropped.
// - offsets, config and first mask all come out of reset at zero.
// - averaging-disable bit one turns averaging off for faster conversions.
// - attenuator-bypass bit one removes processor supply input attenuators.
// - single-channel bit one stops the input scan and converts one input.
// - the three-bit selector picks that input; codes 000, 011, 100 reserved.
// - shutdown drives every fan output inactive: low, or high when inverted.
// - during shutdown every current duty readback shows zero.
// - mask bits 1 and 2 hide processor and main supply limit alerts.
// - mask bits 4, 5, 6 hide remote 1, local, remote 2 alerts.
// - override zero keeps second-bank events alerting even if fully masked.
// - override one with full second mask keeps second-bank events silent.
package toa_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_REMOTE1_OFFSET = 8'h70;
  localparam logic [7:0] IDX_LOCAL_OFFSET   = 8'h71;
  localparam logic [7:0] IDX_REMOTE2_OFFSET = 8'h72;
  localparam logic [7:0] IDX_MEAS_CONFIG    = 8'h73;
  localparam logic [7:0] IDX_ALERT_MASK1    = 8'h74;
  localparam logic [7:0] IDX_BANK_STATE     = 8'h7E;
  localparam logic [7:0] IDX_BANK_CTRL      = 8'h7F;

  // ---------------------------------------------------------------
  // field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int         CFG_AVERAGE_BIT  = 4;
  localparam int         CFG_BYPASS_BIT   = 5;
  localparam int         CFG_SINGLE_BIT   = 6;
  localparam int         CFG_PWRDOWN_BIT  = 7;
  localparam logic [7:0] CFG_WR_MASK      = 8'hF0;
  localparam int         MSK_PROC_BIT     = 1;
  localparam int         MSK_MAIN_BIT     = 2;
  localparam int         MSK_REMOTE1_BIT  = 4;
  localparam int         MSK_LOCAL_BIT    = 5;
  localparam int         MSK_REMOTE2_BIT  = 6;
  localparam int         MSK_OVERRIDE_BIT = 7;
  localparam logic [7:0] MSK_WR_MASK      = 8'hF6;
  localparam logic [7:0] MSK_LIMIT_BITS   = 8'h76;
  localparam int         CTRL_LOCK_BIT    = 0;
  localparam int         CTRL_POLAR_BIT   = 1;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // ---------------------------------------------------------------
  // single-channel selector codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_PROCESSOR_SUPPLY = 3'h1;
  localparam logic [2:0] SEL_MAIN_SUPPLY      = 3'h2;
  localparam logic [2:0] SEL_REMOTE1_TEMP     = 3'h5;
  localparam logic [2:0] SEL_LOCAL_TEMP       = 3'h6;
  localparam logic [2:0] SEL_REMOTE2_TEMP     = 3'h7;

  // temperatures are 10-bit two's complement in quarter degrees
  localparam int TEMP_W    = 10;
  localparam int CHANNELS  = 3;
  localparam int FANS      = 4;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_WRITE  = 4'b0010,
    ST_RDWAIT = 4'b0100,
    ST_RDOUT  = 4'b1000
  } toa_bus_state_t;

  function automatic logic select_legal(input logic [2:0] sel);
    select_legal = (sel == SEL_PROCESSOR_SUPPLY) || (sel == SEL_MAIN_SUPPLY)
                || (sel == SEL_REMOTE1_TEMP) || (sel == SEL_LOCAL_TEMP)
                || (sel == SEL_REMOTE2_TEMP);
  endfunction : select_legal

  // offset unit is half a degree, two quarter-degree steps; saturating
  function automatic logic [TEMP_W-1:0] add_offset(
    input logic [TEMP_W-1:0] raw,
    input logic [7:0]        off);
    logic [TEMP_W+1:0] sum;
    sum = {{2{raw[TEMP_W-1]}}, raw} + {{3{off[7]}}, off, 1'b0};
    if (sum[TEMP_W+1:TEMP_W-1] == 3'h0 || sum[TEMP_W+1:TEMP_W-1] == 3'h7)
      add_offset = sum[TEMP_W-1:0];
    else if (sum[TEMP_W+1] == 1'b0)
      add_offset = 10'h1FF;
    else
      add_offset = 10'h200;
  endfunction : add_offset

endpackage : toa_pkg

/* File: hdl/toa_cfg_if.sv */
// configuration carried from the register bank to its helpers
// assumes all parties share hclk
`timescale 1ns/10ps
interface toa_cfg_if;
  import toa_pkg::*;
  logic [CHANNELS-1:0][7:0] offset;
  logic [7:0]               mask1;
  logic                     alert_active;

  modport bank  (output offset, output mask1, input alert_active);
  modport adder (input offset);
  modport alert (input mask1, output alert_active);
endinterface : toa_cfg_if

/* File: hdl/toa_offset_adder.sv */
// adds the signed per-channel offsets to incoming temperature results
// assumes one result strobe per channel, synchronous to hclk
`timescale 1ns/10ps
module toa_offset_adder
  import toa_pkg::*;
(
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  toa_cfg_if.adder                            cfg,
  input  wire logic [CHANNELS-1:0][TEMP_W-1:0] temp_raw,
  input  wire logic [CHANNELS-1:0]            temp_valid,
  output logic      [CHANNELS-1:0][TEMP_W-1:0] temp_corr,
  output logic      [CHANNELS-1:0]            temp_corr_valid
);

  // ---------------------------------------------------------------
  // correction, channel 0 remote 1, 1 local, 2 remote 2
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      temp_corr       <= '0;
      temp_corr_valid <= '0;
    end
    else
    begin
      temp_corr_valid <= temp_valid;
      for (int i = 0; i < CHANNELS; i++)
        if (temp_valid[i])
          temp_corr[i] <= add_offset(temp_raw[i], cfg.offset[i]);
    end
  end

  a_offset_sum: assert property (@(posedge hclk) disable iff (!hresetn)
    temp_valid[0] && temp_valid[1] && temp_valid[2] |=>
      temp_corr[0] == add_offset($past(temp_raw[0]), $past(cfg.offset[0]))
   && temp_corr[1] == add_offset($past(temp_raw[1]), $past(cfg.offset[1]))
   && temp_corr[2] == add_offset($past(temp_raw[2]), $past(cfg.offset[2])))
    else $error("corrected temperature wrong");

endmodule : toa_offset_adder

/* File: hdl/toa_alert_gate.sv */
// gates limit and second-bank events onto the active-low alert line
// assumes status flags are held by their owners until cleared
`timescale 1ns/10ps
module toa_alert_gate
  import toa_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  toa_cfg_if.alert        cfg,
  input  wire logic [7:0] limit_flags,
  input  wire logic [7:0] status2_flags,
  input  wire logic [7:0] mask2_bits,
  output logic            alert_n
);

  logic first_hit;
  logic second_hit;
  logic next_alert;

  // ---------------------------------------------------------------
  // event combining
  // ---------------------------------------------------------------
  assign first_hit  = |(limit_flags & ~cfg.mask1 & MSK_LIMIT_BITS);
  // a fully masked second bank still alerts unless overridden
  assign second_hit = (|(status2_flags & ~mask2_bits))
                   || ((&mask2_bits) && (|status2_flags)
                       && !cfg.mask1[MSK_OVERRIDE_BIT]);
  assign next_alert = first_hit || second_hit;
  assign cfg.alert_active = !alert_n;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alert_n <= 1'b1;
    else
      alert_n <= !next_alert;
  end

  a_alert_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    (status2_flags == 8'h00) && ((limit_flags & ~cfg.mask1 & 8'h76) == 8'h00)
    |=> alert_n) else $error("alert raised by masked flag");
  a_alert_unmasked: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(limit_flags & ~cfg.mask1 & 8'h76)) |=> !alert_n)
    else $error("unmasked flag gave no alert");
  a_override_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask2_bits == 8'hFF) && (status2_flags != 8'h00)
    && !cfg.mask1[7] |=> !alert_n)
    else $error("second bank alert lost");
  a_override_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask2_bits == 8'hFF) && cfg.mask1[7] && ((limit_flags & ~cfg.mask1
    & 8'h76) == 8'h00) |=> alert_n)
    else $error("overridden second bank alerted");

endmodule : toa_alert_gate

/* File: hdl/toa_bank.sv */
// top of the offset, measurement config and first alert mask bank
// assumes AHB-Lite single word transfers, one slave on the bus
`timescale 1ns/10ps
module toa_bank
  import toa_pkg::*;
(
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire logic [CHANNELS-1:0][TEMP_W-1:0] temp_raw,
  input  wire logic [CHANNELS-1:0]             temp_valid,
  output logic      [CHANNELS-1:0][TEMP_W-1:0] temp_corr,
  output logic      [CHANNELS-1:0]             temp_corr_valid,
  input  wire logic [7:0]                      limit_flags,
  input  wire logic [7:0]                      status2_flags,
  input  wire logic [7:0]                      mask2_bits,
  output logic                                 alert_n,
  input  wire logic [FANS-1:0]                 fan_pwm_in,
  output logic      [FANS-1:0]                 fan_drive,
  input  wire logic [FANS-1:0][7:0]            duty_in,
  output logic      [FANS-1:0][7:0]            duty_readback,
  input  wire logic [2:0]                      channel_select_in,
  output logic                                 averaging_disable,
  output logic                                 attenuator_bypass,
  output logic                                 single_channel_mode,
  output logic      [2:0]                      single_channel_select,
  output logic                                 single_channel_valid,
  output logic                                 power_down_request,
  output logic                                 drive_polarity_invert
);

  toa_cfg_if cfg ();

  toa_bus_state_t state;
  toa_bus_state_t next_state;
  logic [7:0]     bus_idx;
  logic [7:0]     next_idx;
  logic           accept;
  logic [7:0]     meas_config;
  logic [7:0]     alert_mask_first;
  logic [7:0]     remote1_temp_offset;
  logic [7:0]     local_temp_offset;
  logic [7:0]     remote2_temp_offset;
  logic           config_lock;
  logic           wr_active;
  logic           wr_guarded;
  logic [7:0]     wr_byte;
  logic [7:0]     rd_mux;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  // reads take one wait state so a write just ahead is always seen
  assign accept    = hsel && htrans[1] && hready;
  assign next_idx  = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
  assign hreadyout = (state != ST_RDWAIT);
  assign hresp     = 1'b0;

  always_comb
  begin
    next_state = ST_IDLE;
    unique case (state)
      ST_RDWAIT: next_state = ST_RDOUT;
      ST_IDLE, ST_WRITE, ST_RDOUT:
        if (accept)
          next_state = hwrite ? ST_WRITE : ST_RDWAIT;
        else
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bus_idx <= 8'h00;
    else if (accept)
      bus_idx <= next_idx;
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign wr_active  = (state == ST_WRITE);
  assign wr_guarded = wr_active && !config_lock;
  assign wr_byte    = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      remote1_temp_offset <= REG_RESET;
      local_temp_offset   <= REG_RESET;
      remote2_temp_offset <= REG_RESET;
    end
    else if (wr_guarded)
    begin
      if (bus_idx == IDX_REMOTE1_OFFSET)
        remote1_temp_offset <= wr_byte;
      if (bus_idx == IDX_LOCAL_OFFSET)
        local_temp_offset <= wr_byte;
      if (bus_idx == IDX_REMOTE2_OFFSET)
        remote2_temp_offset <= wr_byte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      meas_config <= REG_RESET;
    else if (wr_guarded && bus_idx == IDX_MEAS_CONFIG)
      meas_config <= wr_byte & CFG_WR_MASK;
  end

  // the mask stays writable under lock so alerts can still be tamed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alert_mask_first <= REG_RESET;
    else if (wr_active && bus_idx == IDX_ALERT_MASK1)
      alert_mask_first <= wr_byte & MSK_WR_MASK;
  end

  // lock only clears at reset, a stray write cannot unlock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_lock           <= 1'b0;
      drive_polarity_invert <= 1'b0;
    end
    else if (wr_active && bus_idx == IDX_BANK_CTRL)
    begin
      config_lock           <= config_lock | wr_byte[CTRL_LOCK_BIT];
      drive_polarity_invert <= wr_byte[CTRL_POLAR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (bus_idx)
      IDX_REMOTE1_OFFSET: rd_mux = remote1_temp_offset;
      IDX_LOCAL_OFFSET:   rd_mux = local_temp_offset;
      IDX_REMOTE2_OFFSET: rd_mux = remote2_temp_offset;
      IDX_MEAS_CONFIG:    rd_mux = meas_config;
      IDX_ALERT_MASK1:    rd_mux = alert_mask_first;
      IDX_BANK_CTRL:      rd_mux = {6'h00, drive_polarity_invert, config_lock};
      IDX_BANK_STATE:     rd_mux = {5'h00, single_channel_valid,
                                    meas_config[CFG_PWRDOWN_BIT],
                                    cfg.alert_active};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (state == ST_RDWAIT)
      hrdata <= {24'h000000, rd_mux};
  end

  // ---------------------------------------------------------------
  // measurement control
  // ---------------------------------------------------------------
  assign averaging_disable   = meas_config[CFG_AVERAGE_BIT];
  assign attenuator_bypass   = meas_config[CFG_BYPASS_BIT];
  assign single_channel_mode = meas_config[CFG_SINGLE_BIT];
  assign power_down_request  = meas_config[CFG_PWRDOWN_BIT];

  // reserved codes leave the scan running rather than pick a dead input
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      single_channel_select <= 3'h0;
      single_channel_valid  <= 1'b0;
    end
    else
    begin
      single_channel_select <= channel_select_in;
      single_channel_valid  <= meas_config[CFG_SINGLE_BIT]
                            && select_legal(channel_select_in);
    end
  end

  // ---------------------------------------------------------------
  // fan outputs in shutdown
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fan_drive     <= '0;
      duty_readback <= '0;
    end
    else if (meas_config[CFG_PWRDOWN_BIT])
    begin
      fan_drive     <= {FANS{drive_polarity_invert}};
      duty_readback <= '0;
    end
    else
    begin
      fan_drive     <= fan_pwm_in ^ {FANS{drive_polarity_invert}};
      duty_readback <= duty_in;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  assign cfg.offset = {remote2_temp_offset, local_temp_offset,
                       remote1_temp_offset};
  assign cfg.mask1  = alert_mask_first;

  toa_offset_adder u_adder (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .cfg             (cfg),
    .temp_raw        (temp_raw),
    .temp_valid      (temp_valid),
    .temp_corr       (temp_corr),
    .temp_corr_valid (temp_corr_valid)
  );

  toa_alert_gate u_alert (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .cfg           (cfg),
    .limit_flags   (limit_flags),
    .status2_flags (status2_flags),
    .mask2_bits    (mask2_bits),
    .alert_n       (alert_n)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_lock_blocks_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_active && config_lock |=>
      remote1_temp_offset == $past(remote1_temp_offset)
   && local_temp_offset == $past(local_temp_offset)
   && remote2_temp_offset == $past(remote2_temp_offset)
   && meas_config == $past(meas_config))
    else $error("locked register changed");

  a_unlocked_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_active && !config_lock && bus_idx == 8'h71 |=>
      local_temp_offset == $past(hwdata[7:0]))
    else $error("offset write lost");

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    meas_config[3:0] == 4'h0 && alert_mask_first[0] == 1'b0
    && alert_mask_first[3] == 1'b0)
    else $error("reserved bit set");

  a_shutdown_fans: assert property (@(posedge hclk) disable iff (!hresetn)
    meas_config[7] |=> fan_drive == {4{$past(drive_polarity_invert)}})
    else $error("fan driven in shutdown");

  a_shutdown_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    meas_config[7] ##1 meas_config[7] |-> duty_readback == 32'h0)
    else $error("duty nonzero in shutdown");

  a_single_pick: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 single_channel_valid == ($past(meas_config[6])
      && select_legal($past(channel_select_in))))
    else $error("single channel select wrong");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_config_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_active && !config_lock && bus_idx == IDX_MEAS_CONFIG |=>
      meas_config == ($past(hwdata[7:0]) & 8'hF0))
    else $error("config write wrong");

  a_mask_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_active && bus_idx == IDX_ALERT_MASK1 |=>
      alert_mask_first == ($past(hwdata[7:0]) & 8'hF6))
    else $error("mask write lost");

  a_lock_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    config_lock |=> config_lock)
    else $error("lock bit cleared");

  a_fan_running: assert property (@(posedge hclk) disable iff (!hresetn)
    !meas_config[7] && $past(hresetn) |=> fan_drive == ($past(fan_pwm_in)
      ^ {4{$past(drive_polarity_invert)}}))
    else $error("fan drive wrong outside shutdown");

endmodule : toa_bank

/* File: testbench/toa_alert_rx.sv */
// alert line receiver standing in for the host side
// assumes alert_n is an active-low level synchronous to hclk
`timescale 1ns/10ps
module toa_alert_rx
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic alert_n,
  output logic      seen
);
  // sticky, so an alert between two polls is not lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seen <= 1'b0;
    else if (!alert_n)
      seen <= 1'b1;
  end
endmodule : toa_alert_rx

/* File: testbench/test_toa_bank.sv */
// self-checking bench of the offset, config and alert-mask bank
// assumes an AHB-Lite single slave with hready tied to hreadyout
`timescale 1ns/10ps
module test_toa_bank
  import toa_pkg::*;
();
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  localparam logic [7:0] SEL_OK = 8'hE6;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [CHANNELS-1:0][TEMP_W-1:0] temp_raw = '0;
  logic [CHANNELS-1:0] temp_valid = '0;
  logic [CHANNELS-1:0][TEMP_W-1:0] temp_corr;
  logic [CHANNELS-1:0] temp_corr_valid;
  logic [7:0] limit_flags = 8'h00;
  logic [7:0] status2_flags = 8'h00;
  logic [7:0] mask2_bits = 8'h00;
  logic alert_n;
  logic seen;
  logic [FANS-1:0] fan_pwm_in = 4'hA;
  logic [FANS-1:0] fan_drive;
  logic [FANS-1:0][7:0] duty_in = {4{8'h5A}};
  logic [FANS-1:0][7:0] duty_readback;
  logic [2:0] channel_select_in = 3'h0;
  logic [2:0] single_channel_select;
  logic averaging_disable, attenuator_bypass, single_channel_mode;
  logic single_channel_valid, power_down_request, drive_polarity_invert;
  int miscompares = 0;
  int checked = 0;

  toa_bank toa_bank_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .temp_raw, .temp_valid, .temp_corr, .temp_corr_valid, .limit_flags,
    .status2_flags, .mask2_bits, .alert_n, .fan_pwm_in, .fan_drive,
    .duty_in, .duty_readback, .channel_select_in, .averaging_disable,
    .attenuator_bypass, .single_channel_mode, .single_channel_select,
    .single_channel_valid, .power_down_request, .drive_polarity_invert);
  toa_alert_rx toa_alert_rx_i (.hclk, .hresetn, .alert_n, .seen);

  always #2.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // no cycle count assumed; a hang is left to the watchdog
  task automatic wait_rdy;
    do
    begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, e);
    chk(hresp, 32'h0);
  endtask : rd

  // registered outputs follow one edge after their cause
  task automatic settle;
    repeat (2) @(negedge hclk);
  endtask : settle

  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd(IDX_REMOTE1_OFFSET + 8'(i), 32'h0);
    chk(alert_n, 32'h1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs;
    wr(IDX_REMOTE1_OFFSET, 8'h03);
    rd(IDX_REMOTE1_OFFSET, 32'h03);
    wr(IDX_LOCAL_OFFSET, 8'hFC);
    rd(IDX_LOCAL_OFFSET, 32'hFC);
    wr(IDX_REMOTE2_OFFSET, 8'h7F);
    rd(IDX_REMOTE2_OFFSET, 32'h7F);
    wr(IDX_MEAS_CONFIG, 8'h0F);
    rd(IDX_MEAS_CONFIG, 32'h00);
    wr(IDX_ALERT_MASK1, 8'hFF);
    rd(IDX_ALERT_MASK1, 32'hF6);
    wr(8'h78, 8'hFF);
    rd(8'h78, 32'h00);
    wr(IDX_ALERT_MASK1, 8'h00);
    $display("register test done");
  endtask : t_regs

  task automatic t_offset;
    @(posedge hclk);
    temp_raw <= {10'h1F0, 10'h010, 10'h010};
    temp_valid <= 3'h7;
    @(posedge hclk);
    temp_valid <= 3'h0;
    @(negedge hclk);
    chk(temp_corr_valid, 32'h7);
    chk(temp_corr[0], 32'h016);
    chk(temp_corr[1], 32'h008);
    chk(temp_corr[2], 32'h1FF);
    $display("offset test done");
  endtask : t_offset

  task automatic t_config;
    wr(IDX_MEAS_CONFIG, 8'hF0);
    settle();
    chk({power_down_request, single_channel_mode, attenuator_bypass,
         averaging_disable}, 32'hF);
    chk(fan_drive, 32'h0);
    chk(duty_readback, 32'h0);
    wr(IDX_BANK_CTRL, 8'h02);
    settle();
    chk(fan_drive, 32'hF);
    chk(drive_polarity_invert, 32'h1);
    wr(IDX_MEAS_CONFIG, 8'h40);
    settle();
    chk(fan_drive, 32'h5);
    chk(duty_readback, 32'h5A5A5A5A);
    for (int s = 0; s < 8; s++)
    begin
      @(posedge hclk);
      channel_select_in <= 3'(s);
      settle();
      chk(single_channel_valid, {31'h0, SEL_OK[s]});
      chk(single_channel_select, 32'(s));
    end
    wr(IDX_MEAS_CONFIG, 8'h00);
    $display("config test done");
  endtask : t_config

  task automatic t_alert;
    int b[5] = '{1, 2, 4, 5, 6};
    foreach (b[i])
    begin
      wr(IDX_ALERT_MASK1, 8'h00);
      limit_flags <= 8'h01 << b[i];
      settle();
      chk(alert_n, 32'h0);
      wr(IDX_ALERT_MASK1, 8'h01 << b[i]);
      settle();
      chk(alert_n, 32'h1);
    end
    @(posedge hclk);
    limit_flags <= 8'h00;
    status2_flags <= 8'h01;
    mask2_bits <= 8'hFF;
    settle();
    chk(alert_n, 32'h0);
    wr(IDX_ALERT_MASK1, 8'h80);
    settle();
    chk(alert_n, 32'h1);
    @(posedge hclk);
    mask2_bits <= 8'hFE;
    settle();
    chk(alert_n, 32'h0);
    $display("alert test done");
  endtask : t_alert

  task automatic t_lock;
    wr(IDX_BANK_CTRL, 8'h01);
    wr(IDX_REMOTE1_OFFSET, 8'h55);
    rd(IDX_REMOTE1_OFFSET, 32'h03);
    wr(IDX_MEAS_CONFIG, 8'h80);
    rd(IDX_MEAS_CONFIG, 32'h00);
    wr(IDX_ALERT_MASK1, 8'h10);
    rd(IDX_ALERT_MASK1, 32'h10);
    wr(IDX_BANK_CTRL, 8'h00);
    rd(IDX_BANK_CTRL, 32'h01);
    rd(IDX_BANK_STATE, 32'h01);
    chk(seen, 32'h1);
    $display("lock test done");
  endtask : t_lock

  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_offset();
    t_config();
    t_alert();
    t_lock();
    conclude();
  end

  // the whole run needs well under a tenth of this span
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    conclude();
  end
endmodule : test_toa_bank
